// File: hdl/flash_sleep_device.sv
// Device end: deep-sleep release, identifier stream, busy timing
`timescale 1ns/1ps
module flash_sleep_device
  import sleep_release_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = STANDBY_RECOVERY_CYC,
  parameter int unsigned SUSPEND_CYC  = SUSPEND_LATENCY_CYC,
  parameter int unsigned CONFIG_CYC   = CONFIG_WRITE_CYC,
  parameter logic [7:0]  DEVICE_ID    = 8'h5A  // Arbitrary identifier value
) (
  input  wire logic   mclk_in,
  input  wire logic   arst_n_in,
  serial_link_if.device_mp link,
  input  wire logic   supply_ok_in,
  output logic        ready_out,
  output logic        sleeping_out,
  output logic        busy_out,
  output logic        suspended_out,
  output logic [7:0]  last_cmd_out
);
  initial begin
    if (RECOVERY_CYC < 1 || RECOVERY_CYC >= (1 << CNT_W) || CONFIG_CYC >= (1 << CNT_W)
        || SUSPEND_CYC < 1 || CONFIG_CYC < 1) begin
      $error("flash_sleep_device counts out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift in command, shift out identifier
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       cmd_done_reg;
  logic [7:0] cmd_hold_reg;
  logic       cmd_tgl_reg;
  logic [7:0] id_sh_reg;
  logic       out_en_reg;
  logic       sup_lk_s1_reg;
  logic       sup_lk_reg;

  // Supply level crosses into the link domain; sampled only in frames
  always_ff @(posedge link.sclk or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sup_lk_s1_reg   <= 1'b0;
      sup_lk_reg      <= 1'b0;
    end else begin
      sup_lk_s1_reg   <= supply_ok_in;
      sup_lk_reg      <= sup_lk_s1_reg;
    end
  end

  // Frame logic is cleared by the frame's own select edge, not the stopped clock
  always_ff @(posedge link.sclk or posedge link.sel_n) begin
    if (link.sel_n) begin
      bit_cnt_reg  <= '0;
      shift_reg    <= '0;
      cmd_done_reg <= 1'b0;
    end else if (!cmd_done_reg) begin
      shift_reg   <= {shift_reg[6:0], link.mosi};
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == 4'(CMD_BITS - 1)) begin
        cmd_done_reg <= 1'b1;
      end
    end else if (bit_cnt_reg != 4'(CMD_BITS + DUMMY_CLOCKS)) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // Completed command handed over by toggle; low supply drops it at the source
  always_ff @(posedge link.sclk or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_tgl_reg  <= 1'b0;
      cmd_hold_reg <= '0;
    end else if (!link.sel_n && !cmd_done_reg && bit_cnt_reg == 4'(CMD_BITS - 1)
                 && sup_lk_reg) begin
      cmd_hold_reg <= {shift_reg[6:0], link.mosi};
      cmd_tgl_reg  <= ~cmd_tgl_reg;
    end
  end

  // Identifier changes on falling edges after the dummy clocks
  always_ff @(negedge link.sclk or posedge link.sel_n) begin
    if (link.sel_n) begin
      out_en_reg <= 1'b0;
      id_sh_reg  <= DEVICE_ID;
    end else if (cmd_done_reg && bit_cnt_reg == 4'(CMD_BITS + DUMMY_CLOCKS)
                 && shift_reg == SLEEP_RELEASE_CODE && sup_lk_reg) begin
      out_en_reg <= 1'b1;
      if (out_en_reg) begin
        id_sh_reg <= {id_sh_reg[6:0], id_sh_reg[7]};
      end
    end
  end

  assign link.miso_o  = id_sh_reg[7];
  assign link.miso_oe = out_en_reg && !link.sel_n;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain
  logic        tgl_s1_reg;
  logic        tgl_s2_reg;
  logic        tgl_s3_reg;
  logic        sel_s1_reg;
  logic        sel_s2_reg;
  logic        sel_s3_reg;
  logic        sup_s1_reg;
  logic        sup_s2_reg;
  logic        cmd_pend_reg;
  power_mode_t mode_reg;
  logic [CNT_W-1:0] rec_cnt_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  logic        new_cmd;
  logic        frame_end;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_s3_reg <= 1'b1;
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= cmd_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      sel_s1_reg <= link.sel_n;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      sup_s1_reg <= supply_ok_in;
      sup_s2_reg <= sup_s1_reg;
    end
  end

  assign new_cmd   = tgl_s2_reg ^ tgl_s3_reg;
  assign frame_end = sel_s2_reg && !sel_s3_reg;

  // Release takes effect when select rises, so a command is held until then
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_pend_reg <= 1'b0;
      last_cmd_out <= '0;
    end else if (!sup_s2_reg) begin
      cmd_pend_reg <= 1'b0;
    end else if (new_cmd) begin
      cmd_pend_reg <= 1'b1;
      last_cmd_out <= cmd_hold_reg;
    end else if (frame_end) begin
      cmd_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg    <= MODE_SLEEP;
      rec_cnt_reg <= '0;
    end else if (!sup_s2_reg) begin
      mode_reg    <= MODE_SLEEP;
      rec_cnt_reg <= '0;
    end else begin
      case (mode_reg)
        MODE_SLEEP: begin
          // Every other code is dropped while asleep
          if (frame_end && cmd_pend_reg && last_cmd_out == SLEEP_RELEASE_CODE) begin
            mode_reg    <= MODE_RECOVER;
            rec_cnt_reg <= CNT_W'(RECOVERY_CYC - 1);
          end
        end
        MODE_RECOVER: begin
          if (rec_cnt_reg == '0) begin
            mode_reg <= MODE_STANDBY;
          end else begin
            rec_cnt_reg <= rec_cnt_reg - 1'b1;
          end
        end
        MODE_STANDBY: begin
          if (frame_end && cmd_pend_reg && last_cmd_out == SLEEP_ENTER_CODE && !busy_out) begin
            mode_reg <= MODE_SLEEP;
          end
        end
        default: mode_reg <= MODE_SLEEP;
      endcase
    end
  end

  // Suspend and config write both hold busy for a bounded count
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_cnt_reg  <= '0;
      busy_out      <= 1'b0;
      suspended_out <= 1'b0;
    end else if (!sup_s2_reg) begin
      busy_cnt_reg  <= '0;
      busy_out      <= 1'b0;
      suspended_out <= 1'b0;
    end else if (busy_out) begin
      if (busy_cnt_reg == '0) begin
        busy_out <= 1'b0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end else if (frame_end && cmd_pend_reg && mode_reg == MODE_STANDBY) begin
      if (last_cmd_out == SUSPEND_CODE) begin
        busy_out      <= 1'b1;
        busy_cnt_reg  <= CNT_W'(SUSPEND_CYC - 1);
        suspended_out <= 1'b1;
      end else if (last_cmd_out == CONFIG_WRITE_CODE) begin
        busy_out      <= 1'b1;
        busy_cnt_reg  <= CNT_W'(CONFIG_CYC - 1);
      end
    end
  end

  assign ready_out    = (mode_reg == MODE_STANDBY) && !busy_out && sup_s2_reg;
  assign sleeping_out = (mode_reg != MODE_STANDBY);
endmodule // flash_sleep_device

// File: hdl/flash_sleep_host.sv
// Host end: sends command frames, captures identifier through a FIFO
`timescale 1ns/1ps
module flash_sleep_host
  import sleep_release_pkg::*;
#(
  parameter int unsigned POWER_UP_CYC = SUPPLY_TO_WRITE_CYC,
  parameter int unsigned GAP_CYC      = STANDBY_RECOVERY_CYC,
  parameter int unsigned FIFO_DEPTH   = 8
) (
  input  wire logic   mclk_in,
  input  wire logic   arst_n_in,
  serial_link_if.host_mp link,
  input  wire logic   supply_ok_in,
  input  wire logic [7:0] cmd_in,
  input  wire logic   read_id_in,
  input  wire logic   cmd_valid_in,
  output logic        cmd_ready_out,
  output logic [7:0]  id_data_out,
  output logic        id_valid_out,
  input  wire logic   id_ready_in
);
  initial begin
    if (POWER_UP_CYC >= (1 << CNT_W) || GAP_CYC >= (1 << CNT_W) || GAP_CYC < 1) begin
      $error("flash_sleep_host counts out of range");
    end
  end

  host_state_t      st_reg;
  logic [CNT_W-1:0] wait_reg;
  logic [7:0]       tx_reg;
  logic [4:0]       bits_reg;
  logic [4:0]       total_reg;
  logic [1:0]       div_reg;
  logic             sclk_reg;
  logic             sel_n_reg;
  logic [7:0]       rx_reg;
  logic [2:0]       rx_cnt_reg;
  logic             push_reg;
  logic             fifo_ready;
  logic             miso_s1_reg;
  logic             miso_s2_reg;
  logic             sup_s1_reg;
  logic             sup_ok_reg;
  logic             rise;
  logic             fall;

  // Link clock is derived by dividing the core clock
  assign rise = (st_reg == HOST_SHIFT) && !sclk_reg && div_reg == 2'(CLK_DIV_HALF - 1);
  assign fall = (st_reg == HOST_SHIFT) && sclk_reg && div_reg == 2'(CLK_DIV_HALF - 1);
  assign link.sclk  = sclk_reg;
  assign link.sel_n = sel_n_reg;
  assign link.mosi  = tx_reg[7];
  assign cmd_ready_out = (st_reg == HOST_IDLE);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      miso_s1_reg <= 1'b1;
      miso_s2_reg <= 1'b1;
      sup_s1_reg  <= 1'b0;
      sup_ok_reg  <= 1'b0;
    end else begin
      miso_s1_reg <= link.miso;
      miso_s2_reg <= miso_s1_reg;
      sup_s1_reg  <= supply_ok_in;
      sup_ok_reg  <= sup_s1_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg    <= HOST_WAIT_PU;
      wait_reg  <= '0;
      tx_reg    <= '0;
      bits_reg  <= '0;
      total_reg <= '0;
      div_reg   <= '0;
      sclk_reg  <= 1'b0;
      sel_n_reg <= 1'b1;
    end else begin
      case (st_reg)
        HOST_WAIT_PU: begin
          // Both power-up waits share one counter; write wait is the longer or equal
          if (!sup_ok_reg) begin
            wait_reg <= '0;
          end else if (wait_reg == CNT_W'(POWER_UP_CYC)) begin
            st_reg <= HOST_IDLE;
          end else begin
            wait_reg <= wait_reg + 1'b1;
          end
        end
        HOST_IDLE: begin
          if (!sup_ok_reg) begin
            st_reg   <= HOST_WAIT_PU;
            wait_reg <= '0;
          end else if (cmd_valid_in) begin
            sel_n_reg <= 1'b0;
            tx_reg    <= cmd_in;
            bits_reg  <= '0;
            // Identifier read adds dummy clocks and eight data clocks
            total_reg <= read_id_in ? 5'(CMD_BITS + DUMMY_CLOCKS + ID_BITS)
                                    : 5'(CMD_BITS);
            div_reg   <= '0;
            st_reg    <= HOST_SHIFT;
          end
        end
        HOST_SHIFT: begin
          div_reg <= (div_reg == 2'(CLK_DIV_HALF - 1)) ? 2'b00 : div_reg + 1'b1;
          if (rise) begin
            sclk_reg <= 1'b1;
            bits_reg <= bits_reg + 1'b1;
          end else if (fall) begin
            sclk_reg <= 1'b0;
            tx_reg   <= {tx_reg[6:0], 1'b0};
            if (bits_reg == total_reg) begin
              st_reg <= HOST_DESEL;
            end
          end
        end
        HOST_DESEL: begin
          // Wait until the FIFO takes the pushed identifier byte (push_reg clear), then end the frame
          if (!push_reg) begin
            sel_n_reg <= 1'b1;
            wait_reg  <= CNT_W'(GAP_CYC);
            st_reg    <= HOST_GAP;
          end
        end
        HOST_GAP: begin
          if (wait_reg == '0) begin
            st_reg <= HOST_IDLE;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        default: st_reg <= HOST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identifier capture: taken at falling edges, when the synchronised line
  // holds the bit launched one link clock earlier; the byte is then whole
  // in rx_reg and stays put while a full FIFO stalls the push
  logic sample_now;
  assign sample_now = fall && (total_reg != 5'(CMD_BITS))
                      && bits_reg > 5'(CMD_BITS + DUMMY_CLOCKS);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_reg     <= '0;
      rx_cnt_reg <= '0;
      push_reg   <= 1'b0;
    end else begin
      if (push_reg && fifo_ready) begin
        push_reg <= 1'b0;
      end
      if (st_reg == HOST_IDLE) begin
        rx_cnt_reg <= '0;
      end else if (sample_now) begin
        rx_reg     <= {rx_reg[6:0], miso_s2_reg};
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
        if (rx_cnt_reg == 3'(ID_BITS - 1)) begin
          push_reg <= 1'b1;
        end
      end
    end
  end

  // A full FIFO holds the frame open via DESEL until space frees
  word_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_id_fifo (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .wr_data_in   (rx_reg),
    .wr_valid_in  (push_reg),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (id_data_out),
    .rd_valid_out (id_valid_out),
    .rd_ready_in  (id_ready_in)
  );
endmodule // flash_sleep_host

// File: hdl/serial_link_if.sv
// Serial link between host controller and flash device end
`timescale 1ns/1ps
interface serial_link_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  assign miso = miso_oe ? miso_o : 1'b1;

  modport device_mp (input sel_n, input sclk, input mosi, output miso_o, output miso_oe);
  modport host_mp   (output sel_n, output sclk, output mosi, input miso);
endinterface : serial_link_if

// File: hdl/sleep_release_pkg.sv
// Constants shared by the deep-sleep release device end and its host end
package sleep_release_pkg;

  localparam int unsigned MCLK_MHZ             = 200;
  localparam int unsigned CMD_BITS             = 8;
  localparam int unsigned DUMMY_CLOCKS         = 3;
  localparam int unsigned ID_BITS              = 8;

  localparam logic [7:0]  SLEEP_RELEASE_CODE   = 8'hAB;
  localparam logic [7:0]  SLEEP_ENTER_CODE     = 8'hB9;
  localparam logic [7:0]  SUSPEND_CODE         = 8'hB0;
  localparam logic [7:0]  CONFIG_WRITE_CODE    = 8'h01;
  localparam logic [7:0]  READ_CODE            = 8'h03;

  // Times in their natural units
  localparam int unsigned STANDBY_RECOVERY_US  = 10;
  localparam int unsigned SUPPLY_TO_READ_US    = 100;
  localparam int unsigned SUPPLY_TO_WRITE_US   = 100;
  localparam int unsigned SUSPEND_LATENCY_US   = 25;
  localparam int unsigned CONFIG_WRITE_MS      = 25;

  // Longest times round down, least times round up (integer figures, exact)
  localparam int unsigned STANDBY_RECOVERY_CYC = STANDBY_RECOVERY_US * MCLK_MHZ;
  localparam int unsigned SUPPLY_TO_READ_CYC   = SUPPLY_TO_READ_US * MCLK_MHZ;
  localparam int unsigned SUPPLY_TO_WRITE_CYC  = SUPPLY_TO_WRITE_US * MCLK_MHZ;
  localparam int unsigned SUSPEND_LATENCY_CYC  = SUSPEND_LATENCY_US * MCLK_MHZ;
  localparam int unsigned CONFIG_WRITE_CYC     = CONFIG_WRITE_MS * 1000 * MCLK_MHZ;

  localparam int unsigned CNT_W                = 24;
  localparam int unsigned CLK_DIV_HALF         = 2;

  typedef enum logic [1:0] {
    MODE_SLEEP   = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_RECOVER = 2'b10
  } power_mode_t;

  typedef enum logic [2:0] {
    HOST_IDLE    = 3'b000,
    HOST_WAIT_PU = 3'b001,
    HOST_SHIFT   = 3'b010,
    HOST_DESEL   = 3'b011,
    HOST_GAP     = 3'b100
  } host_state_t;

endpackage : sleep_release_pkg

// File: hdl/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("word_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign wr_ready_out = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign rd_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage has no reset; valid pointers guard every read
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
    end
  end
endmodule // word_fifo

// File: sim/deep_sleep_release_and_id_readout_tb.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module deep_sleep_release_and_id_readout_tb;
  import sleep_release_pkg::*;
  localparam int unsigned REC = 20;
  localparam int unsigned SUS = 10;
  localparam int unsigned CFG = 50;
  localparam int unsigned PWR = 20;
  localparam logic [7:0]  ID_VAL = 8'h5A; // Arbitrary identifier value
  logic       mclk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       supply_ok_in = 1'b1;
  logic [7:0] cmd_in = 8'h00;
  logic       read_id_in = 1'b0;
  logic       cmd_valid_in = 1'b0;
  logic       id_ready_in = 1'b0;
  logic       cmd_ready_out, id_valid_out, ready_out, sleeping_out, busy_out, suspended_out;
  logic [7:0] id_data_out, last_cmd_out;
  int         n_errors = 0;
  int         n_tests = 0;
  int         n;
  logic [7:0] codes [3] = '{CONFIG_WRITE_CODE, SUSPEND_CODE, READ_CODE};

  serial_link_if i_serial_link_if ();
  flash_sleep_device #(.RECOVERY_CYC(REC), .SUSPEND_CYC(SUS), .CONFIG_CYC(CFG),
    .DEVICE_ID(ID_VAL)) i_flash_sleep_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .link(i_serial_link_if.device_mp), .supply_ok_in(supply_ok_in), .ready_out(ready_out),
    .sleeping_out(sleeping_out), .busy_out(busy_out), .suspended_out(suspended_out),
    .last_cmd_out(last_cmd_out));
  flash_sleep_host #(.POWER_UP_CYC(PWR), .GAP_CYC(REC), .FIFO_DEPTH(8)) i_flash_sleep_host (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(i_serial_link_if.host_mp),
    .supply_ok_in(supply_ok_in), .cmd_in(cmd_in), .read_id_in(read_id_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .id_data_out(id_data_out),
    .id_valid_out(id_valid_out), .id_ready_in(id_ready_in));
  sleep_link_monitor #(.RECOVERY_CYC(REC), .SUSPEND_CYC(SUS), .CONFIG_CYC(CFG)) i_mon (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .sel_n(i_serial_link_if.sel_n),
    .sclk(i_serial_link_if.sclk), .mosi(i_serial_link_if.mosi),
    .miso_oe(i_serial_link_if.miso_oe), .supply_ok_in(supply_ok_in), .ready_out(ready_out),
    .sleeping_out(sleeping_out), .busy_out(busy_out), .suspended_out(suspended_out));

  always #2.5 mclk_in = ~mclk_in;
  ////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return ready_out;
      1: return busy_out;
      2: return i_serial_link_if.sel_n;
      3: return id_valid_out;
      default: return cmd_ready_out;
    endcase
  endfunction
  // Bounded wait at falling edges; returns the cycles spent
  task automatic wait_for(input int s, input logic v, output int k);
    for (k = 0; k < 500 && pick(s) !== v; k++) @(negedge mclk_in);
    if (k == 500) begin
      check("wait bound", 16'h0001, 16'h0000);
      final_report();
    end
  endtask
  // Hands one command over, then waits for the frame to close
  task automatic send(input logic [7:0] code, input logic rid);
    int k;
    wait_for(4, 1'b1, k);
    cmd_in = code;
    read_id_in = rid;
    cmd_valid_in = 1'b1;
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
    wait_for(2, 1'b1, k);
  endtask
  task automatic pop();
    id_ready_in = 1'b1;
    @(negedge mclk_in);
    id_ready_in = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(negedge mclk_in);
    arst_n_in = 1'b1;
    @(negedge mclk_in);
    check("sleeping", sleeping_out, 1'b1);
    check("ready", ready_out, 1'b0);
    check("miso idle", i_serial_link_if.miso, 1'b1);
    $display("test reset done");
    foreach (codes[i]) begin
      send(codes[i], 1'b0);
      repeat (6) @(negedge mclk_in);
      check("busy asleep", {busy_out, suspended_out, sleeping_out}, 3'b001);
    end
    $display("test sleep ignore done");
    send(SLEEP_RELEASE_CODE, 1'b0);
    wait_for(0, 1'b1, n);
    check("recovery", n >= REC - 1 && n <= REC + 6, 1'b1);
    check("last command", last_cmd_out, SLEEP_RELEASE_CODE);
    $display("test plain release done");
    send(CONFIG_WRITE_CODE, 1'b0);
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    check("config busy", n >= CFG - 2 && n <= CFG + 2, 1'b1);
    send(SUSPEND_CODE, 1'b0);
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    check("suspend busy", n >= SUS - 2 && n <= SUS + 2, 1'b1);
    check("suspended", suspended_out, 1'b1);
    $display("test busy timing done");
    // Fill the identifier buffer with no reader, then drain it
    repeat (8) begin
      send(SLEEP_ENTER_CODE, 1'b0);
      send(SLEEP_RELEASE_CODE, 1'b1);
      repeat (4) @(negedge mclk_in);
      check("miso released", i_serial_link_if.miso, 1'b1);
      wait_for(0, 1'b1, n);
      check("id recovery", n <= REC + 6, 1'b1);
    end
    repeat (8) begin
      check("id valid", id_valid_out, 1'b1);
      check("id value", id_data_out, ID_VAL);
      pop();
    end
    check("id empty", id_valid_out, 1'b0);
    $display("test identifier stream done");
    supply_ok_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    check("low supply", {sleeping_out, ready_out, busy_out, suspended_out}, 4'h8);
    check("host held", cmd_ready_out, 1'b0);
    supply_ok_in = 1'b1;
    wait_for(4, 1'b1, n);
    check("power-up wait", n >= PWR - 2 && n <= PWR + 6, 1'b1);
    send(SLEEP_RELEASE_CODE, 1'b0);
    wait_for(0, 1'b1, n);
    check("ready again", ready_out, 1'b1);
    $display("test supply loss done");
    final_report();
  end
endmodule // deep_sleep_release_and_id_readout_tb

// File: sim/sleep_link_monitor.sv
// Assertions on the serial link and the device status outputs
`timescale 1ns/1ps
module sleep_link_monitor #(
  parameter int unsigned RECOVERY_CYC = 20,
  parameter int unsigned SUSPEND_CYC  = 10,
  parameter int unsigned CONFIG_CYC   = 50
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic supply_ok_in,
  input wire logic ready_out,
  input wire logic sleeping_out,
  input wire logic busy_out,
  input wire logic suspended_out
);
  logic [15:0] hi_cnt_reg;
  logic [15:0] busy_cnt_reg;
  logic [4:0]  edge_cnt_reg;
  logic        sel_q_reg;
  logic        sclk_q_reg;
  logic        slept_reg;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_q_reg  <= 1'b1;
      sclk_q_reg <= 1'b0;
    end else begin
      sel_q_reg  <= sel_n;
      sclk_q_reg <= sclk;
    end
  end
  // Saturating, so a long idle never wraps into a false recovery figure
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) hi_cnt_reg <= 16'h0000;
    else if (!sel_n) hi_cnt_reg <= 16'h0000;
    else if (hi_cnt_reg != 16'hFFFF) hi_cnt_reg <= hi_cnt_reg + 16'h0001;
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) busy_cnt_reg <= 16'h0000;
    else busy_cnt_reg <= busy_out ? busy_cnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) edge_cnt_reg <= 5'h00;
    else if (sel_q_reg && !sel_n) edge_cnt_reg <= 5'h00;
    else if (sclk && !sclk_q_reg) edge_cnt_reg <= edge_cnt_reg + 5'h01;
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) slept_reg <= 1'b1;
    else if (sleeping_out) slept_reg <= 1'b1;
    else if (ready_out) slept_reg <= 1'b0;
  end
  ////////////////////////////////////////
  sclk_idle_a: assert property (sel_n |-> !sclk)
    else $error("serial clock active while deselected");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("command bit changed while clock high");
  frame_len_a: assert property ($rose(sel_n) |-> edge_cnt_reg inside {5'h08, 5'h13})
    else $error("frame clock count wrong");
  recover_time_a: assert property ($rose(ready_out) && slept_reg |->
    hi_cnt_reg >= RECOVERY_CYC && hi_cnt_reg <= RECOVERY_CYC + 6)
    else $error("standby reached outside recovery window");
  busy_susp_a: assert property (busy_out && suspended_out |->
    busy_cnt_reg <= SUSPEND_CYC + 2)
    else $error("suspend took too long");
  busy_cfg_a: assert property (busy_out |-> busy_cnt_reg <= CONFIG_CYC + 2)
    else $error("config write took too long");
  asleep_idle_a: assert property (sleeping_out |-> !busy_out)
    else $error("busy while asleep");
  supply_low_a: assert property (!supply_ok_in [*6] |->
    sleeping_out && !ready_out && !miso_oe)
    else $error("device active on low supply");
  oe_release_a: assert property ($rose(sel_n) |-> ##[1:6] !miso_oe)
    else $error("output not released after deselect");
  oe_idle_a: assert property (sel_n [*8] |-> !miso_oe)
    else $error("output driven while deselected");
  id_stream_a: assert property (!sel_n && !$past(sel_n) && $past(miso_oe) |-> miso_oe)
    else $error("identifier stream stopped early");
endmodule // sleep_link_monitor
